// File: cfs_consts.svh
// Constants for the charger fault supervisor and its vehicle-side controller.
// Assumes one 20 MHz clock shared by both ends and an active-low asynchronous reset.
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH

`define CFS_CLK_HZ          20000000
`define CFS_WD_MS           1000
`define CFS_PRI_MS          3000
`define CFS_PSTAGE_MS       10000
`define CFS_CALM_MIN        5
`define CFS_CMD_MS          100
`define CFS_BIT_RATE        1000000
`define CFS_MS_CYC          (`CFS_CLK_HZ / 1000)
`define CFS_BIT_CYC         (`CFS_CLK_HZ / `CFS_BIT_RATE)
`define CFS_RETRY_MAX       3'h5
`define CFS_BLINK_MS        250
`define CFS_CMD_ID          11'h190
`define CFS_B_SUMMARY       12
`define CFS_B_OCP           18
`define CFS_B_OTP           20
`define CFS_B_OVP_HW        21
`define CFS_B_OVP_SW        22
`define CFS_B_WD            24
`define CFS_B_FWRST         25
`define CFS_B_PRI           26
`define CFS_B_PSTAGE        28
`define CFS_B_CAL           30

`endif

// File: cfs_pkg.sv
// Types shared by the supervisor and the controller.
// Assumes cfs_consts.svh is on the include path.
package cfs_pkg;
    typedef logic [31:0] cfs_status_t;
    typedef logic [3:0]  cfs_prof_t;
    typedef logic [15:0] cfs_volt_t;
endpackage

// File: cfs_link_if.sv
// Interface carrying decoded CAN traffic between controller and supervisor.
// Assumes framing on the wire is handled elsewhere; a command is a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
interface cfs_link_if;
    import cfs_pkg::*;
    logic        cmd_valid;
    logic [10:0] cmd_id;
    logic        clear_faults_request;
    logic        power_stage_request;
    cfs_volt_t   volt_setpoint;
    cfs_status_t module_status_message;
    cfs_prof_t   profile_fault_message;
    logic        status_valid;

    modport secondary_unit
    (
        input  cmd_valid, cmd_id, clear_faults_request, power_stage_request, volt_setpoint,
        output module_status_message, profile_fault_message, status_valid
    );
    modport controller
    (
        output cmd_valid, cmd_id, clear_faults_request, power_stage_request, volt_setpoint,
        input  module_status_message, profile_fault_message, status_valid
    );
endinterface
`default_nettype wire

// File: cfs_tick.sv
// Millisecond tick divider shared by both ends.
// Assumes the core clock runs at the rate in cfs_consts.svh.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_consts.svh"
module cfs_tick
#(
    parameter int CYC = `CFS_MS_CYC
)
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    output logic      tick
);
    typedef struct packed
    {
        logic [15:0] cnt;
    } cfs_tick_s;
    cfs_tick_s s_q;
    cfs_tick_s s_d;

    always_comb
    begin
        s_d = s_q;
        if (s_q.cnt == 16'(CYC - 1))
            s_d.cnt = 16'h0000;
        else
            s_d.cnt = s_q.cnt + 16'h0001;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign tick = (s_q.cnt == 16'(CYC - 1));
endmodule
`default_nettype wire

// File: cfs_supervisor.sv
// Fault supervisor of the secondary unit.
// Assumes fault detector inputs are synchronous levels and commands arrive as one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_consts.svh"
module cfs_supervisor
#(
    parameter int WD_MS     = `CFS_WD_MS,
    parameter int PRI_MS    = `CFS_PRI_MS,
    parameter int PSTAGE_MS = `CFS_PSTAGE_MS,
    parameter int CALM_MS   = `CFS_CALM_MIN * 60 * 1000,
    parameter int MS_CYC    = `CFS_MS_CYC,
    parameter int BIT_RATE  = `CFS_BIT_RATE
)
(
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    cfs_link_if.secondary_unit   link,
    input  wire logic            profile_mode,
    input  wire logic            external_charge_enable,
    input  wire logic            sleep_mode,
    input  wire logic            charging,
    input  wire logic            over_current,
    input  wire logic            over_temp,
    input  wire logic            over_volt_hard,
    input  wire logic            over_volt_soft,
    input  wire logic            firmware_reset,
    input  wire logic            primary_unit_fault,
    input  wire logic            out_above_demand,
    input  wire cfs_pkg::cfs_volt_t battery_volt,
    input  wire logic            calibration_bad,
    input  wire logic            bad_profile_fault,
    input  wire logic            battery_temp_fault,
    input  wire logic            profile_battery_issue,
    input  wire logic            battery_volt_fault,
    output logic                 power_enable,
    output logic                 fault_lamp,
    output logic [31:0]          can_bit_cycles
);
    import cfs_pkg::*;
    typedef struct packed
    {
        logic        ocp;
        logic        otp;
        logic        ovp_hw;
        logic        ovp_sw;
        logic        wd;
        logic        fwrst;
        logic        pri;
        logic        pstage;
        logic        cal;
        logic        locked;
        logic        was_fault;
        logic        pwr_was_on;
        logic        lamp;
        logic [2:0]  retries;
        logic [15:0] wd_ms;
        logic [15:0] pri_ms;
        logic [15:0] ps_ms;
        logic [15:0] blink_ms;
        logic [19:0] calm_ms;
        cfs_status_t status;
        cfs_prof_t   prof;
        logic        outp;
    } cfs_sup_s;
    cfs_sup_s s_q;
    cfs_sup_s s_d;
    logic     ms;
    logic     cmd_ok;
    logic     clr;
    logic     cycle_on;
    logic     any_fault;

    cfs_tick #(.CYC(MS_CYC)) u_tick
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick     (ms)
    );

    assign cmd_ok   = link.cmd_valid && (link.cmd_id == `CFS_CMD_ID);
    assign clr      = cmd_ok && link.clear_faults_request && !profile_mode;
    assign cycle_on = cmd_ok && link.power_stage_request && !s_q.pwr_was_on;

    always_comb
    begin
        s_d = s_q;
        if (cmd_ok)
            s_d.pwr_was_on = link.power_stage_request;
        // --------------------------------------------------------------------
        // Watchdog
        // --------------------------------------------------------------------
        if (cmd_ok || profile_mode)
            s_d.wd_ms = 16'h0000;
        else if (ms && s_q.wd_ms != 16'(WD_MS))
            s_d.wd_ms = s_q.wd_ms + 16'h0001;
        if (clr)
            s_d.wd = 1'b0;
        if (!profile_mode && !cmd_ok && s_q.wd_ms == 16'(WD_MS))
            s_d.wd = 1'b1;
        // --------------------------------------------------------------------
        // Latching faults: cleared by power cycle in CAN mode, retried in profile mode
        // --------------------------------------------------------------------
        if (profile_mode)
        begin
            if (!s_q.locked)
            begin
                s_d.ocp    = 1'b0;
                s_d.ovp_hw = 1'b0;
                s_d.ovp_sw = 1'b0;
                s_d.fwrst  = 1'b0;
            end
        end
        else if (cycle_on)
        begin
            s_d.ocp    = 1'b0;
            s_d.ovp_hw = 1'b0;
            s_d.ovp_sw = 1'b0;
            s_d.fwrst  = 1'b0;
        end
        if (over_current)
            s_d.ocp = 1'b1;
        if (over_volt_hard)
            s_d.ovp_hw = 1'b1;
        if (over_volt_soft)
            s_d.ovp_sw = 1'b1;
        if (firmware_reset)
            s_d.fwrst = 1'b1;
        // --------------------------------------------------------------------
        // Self-clearing faults, and the calibration fault cleared by a clear request in CAN mode
        // --------------------------------------------------------------------
        s_d.otp = over_temp;
        if (primary_unit_fault)
        begin
            s_d.pri    = 1'b1;
            s_d.pri_ms = 16'h0000;
        end
        else if (s_q.pri && ms)
        begin
            if (s_q.pri_ms == 16'(PRI_MS - 1))
                s_d.pri = 1'b0;
            else
                s_d.pri_ms = s_q.pri_ms + 16'h0001;
        end
        if (charging && out_above_demand)
        begin
            if (ms && s_q.ps_ms != 16'(PSTAGE_MS))
                s_d.ps_ms = s_q.ps_ms + 16'h0001;
        end
        else
            s_d.ps_ms = 16'h0000;
        if (link.volt_setpoint > battery_volt)
            s_d.pstage = 1'b0;
        if ((charging && s_q.ps_ms == 16'(PSTAGE_MS)) || (!charging && out_above_demand))
            s_d.pstage = 1'b1;
        if (clr)
            s_d.cal = 1'b0;
        if (calibration_bad)
            s_d.cal = 1'b1;
        // --------------------------------------------------------------------
        // Retry counting and lockout
        // --------------------------------------------------------------------
        if (profile_mode && any_fault && !s_q.was_fault && !s_q.locked)
        begin
            if (s_q.retries == `CFS_RETRY_MAX)
                s_d.locked = 1'b1;
            else
                s_d.retries = s_q.retries + 3'h1;
        end
        s_d.was_fault = any_fault;
        if (any_fault)
            s_d.calm_ms = 20'h00000;
        else if (ms)
        begin
            if (s_q.calm_ms == 20'(CALM_MS - 1))
            begin
                s_d.calm_ms = 20'h00000;
                s_d.retries = 3'h0;
            end
            else
                s_d.calm_ms = s_q.calm_ms + 20'h00001;
        end
        // --------------------------------------------------------------------
        // Reporting and output
        // --------------------------------------------------------------------
        s_d.status                   = '0;
        s_d.status[`CFS_B_OCP]       = s_q.ocp;
        s_d.status[`CFS_B_OTP]       = s_q.otp;
        s_d.status[`CFS_B_OVP_HW]    = s_q.ovp_hw;
        s_d.status[`CFS_B_OVP_SW]    = s_q.ovp_sw;
        s_d.status[`CFS_B_WD]        = s_q.wd;
        s_d.status[`CFS_B_FWRST]     = s_q.fwrst;
        s_d.status[`CFS_B_PRI]       = s_q.pri;
        s_d.status[`CFS_B_PSTAGE]    = s_q.pstage;
        s_d.status[`CFS_B_CAL]       = s_q.cal;
        s_d.prof = profile_mode ? {battery_volt_fault, profile_battery_issue,
                                   battery_temp_fault, bad_profile_fault} : 4'h0;
        s_d.status[`CFS_B_SUMMARY]   = any_fault || (s_d.prof != 4'h0);
        s_d.outp = !any_fault && (link.volt_setpoint > battery_volt) &&
                   (profile_mode ? (external_charge_enable && !sleep_mode)
                                 : s_q.pwr_was_on);
        if (!any_fault)
        begin
            s_d.lamp     = 1'b0;
            s_d.blink_ms = 16'h0000;
        end
        else if (ms)
        begin
            if (s_q.blink_ms == 16'(`CFS_BLINK_MS - 1))
            begin
                s_d.blink_ms = 16'h0000;
                s_d.lamp     = !s_q.lamp;
            end
            else
                s_d.blink_ms = s_q.blink_ms + 16'h0001;
        end
    end

    assign any_fault = s_q.ocp | s_q.otp | s_q.ovp_hw | s_q.ovp_sw | s_q.wd | s_q.fwrst |
                       s_q.pri | s_q.pstage | s_q.cal | s_q.locked | (|s_q.prof);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign power_enable               = s_q.outp;
    assign fault_lamp                 = s_q.lamp;
    assign link.module_status_message = s_q.status;
    assign link.profile_fault_message = s_q.prof;
    assign link.status_valid          = 1'b1;
    assign can_bit_cycles             = 32'(`CFS_CLK_HZ / BIT_RATE);
endmodule
`default_nettype wire

// File: cfs_controller.sv
// Vehicle-side controller end: sends periodic charging commands.
// Assumes the user side holds its request levels steady between commands.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_consts.svh"
module cfs_controller
#(
    parameter int CMD_MS   = `CFS_CMD_MS,
    parameter int MS_CYC   = `CFS_MS_CYC,
    parameter int BIT_RATE = `CFS_BIT_RATE
)
(
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    cfs_link_if.controller     link,
    input  wire logic          user_power_on,
    input  wire logic          user_clear,
    input  wire cfs_pkg::cfs_volt_t user_setpoint,
    output cfs_pkg::cfs_status_t    seen_status,
    output cfs_pkg::cfs_prof_t      seen_profile,
    output logic               seen_fault,
    output logic [31:0]        can_bit_cycles
);
    import cfs_pkg::*;
    typedef struct packed
    {
        logic [15:0] ms_cnt;
        logic        clr_pend;
        logic        send;
        logic        clr;
        logic        pwr;
        cfs_volt_t   setp;
        cfs_status_t stat;
        cfs_prof_t   prof;
    } cfs_ctl_s;
    cfs_ctl_s s_q;
    cfs_ctl_s s_d;
    logic     ms;

    cfs_tick #(.CYC(MS_CYC)) u_tick
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick     (ms)
    );

    always_comb
    begin
        s_d      = s_q;
        s_d.send = 1'b0;
        if (user_clear)
            s_d.clr_pend = 1'b1;
        if (ms)
        begin
            if (s_q.ms_cnt == 16'(CMD_MS - 1))
            begin
                s_d.ms_cnt   = 16'h0000;
                s_d.send     = 1'b1;
                s_d.clr      = s_q.clr_pend || user_clear;
                s_d.clr_pend = 1'b0;
                s_d.pwr      = user_power_on;
                s_d.setp     = user_setpoint;
            end
            else
                s_d.ms_cnt = s_q.ms_cnt + 16'h0001;
        end
        if (link.status_valid)
        begin
            s_d.stat = link.module_status_message;
            s_d.prof = link.profile_fault_message;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign link.cmd_valid            = s_q.send;
    assign link.cmd_id               = `CFS_CMD_ID;
    assign link.clear_faults_request = s_q.clr;
    assign link.power_stage_request  = s_q.pwr;
    assign link.volt_setpoint        = s_q.setp;
    assign seen_status               = s_q.stat;
    assign seen_profile              = s_q.prof;
    assign seen_fault                = s_q.stat[`CFS_B_SUMMARY];
    assign can_bit_cycles            = 32'(`CFS_CLK_HZ / BIT_RATE);
endmodule
`default_nettype wire

// File: cfs_link_checker.sv
// Concurrent checks on the command and status link between the two ends.
// Assumes it is instantiated beside the interface with the shortened counts of the bench.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_consts.svh"
module cfs_link_checker
#(
    parameter int CMD_CYC = 20,
    parameter int PRI_CYC = 40
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  wire logic [10:0] cmd_id,
    input  wire logic        clear_faults_request,
    input  wire logic        power_stage_request,
    input  wire cfs_pkg::cfs_volt_t   volt_setpoint,
    input  wire cfs_pkg::cfs_status_t module_status_message,
    input  wire cfs_pkg::cfs_prof_t   profile_fault_message,
    input  wire logic        status_valid
);
    import cfs_pkg::*;
    // ----------------------------------------------------------------
    // Constants and sequences.
    // ----------------------------------------------------------------
    localparam int          CMD_LO   = CMD_CYC - 9;
    localparam int          CMD_HI   = CMD_CYC - 7;
    localparam int          PRI_PAST = PRI_CYC - 2;
    localparam cfs_status_t FMASK    = 32'h5774_0000;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_quiet;
        !cmd_valid [*8];
    endsequence
    // ----------------------------------------------------------------
    // Properties.
    // ----------------------------------------------------------------
    property p_cmd_id;
        cmd_valid |-> cmd_id == `CFS_CMD_ID;
    endproperty
    property p_cmd_period;
        cmd_valid |=> s_quiet ##[CMD_LO:CMD_HI] cmd_valid;
    endproperty
    property p_sum_set;
        ((module_status_message & FMASK) != '0) || (profile_fault_message != '0)
            |-> module_status_message[`CFS_B_SUMMARY];
    endproperty
    property p_sum_fall;
        $fell(module_status_message[`CFS_B_SUMMARY])
            |-> (module_status_message & FMASK) == '0 && profile_fault_message == '0;
    endproperty
    property p_spare;
        (module_status_message & ~(FMASK | 32'h0000_1000)) == '0;
    endproperty
    property p_valid;
        status_valid;
    endproperty
    property p_no_wd;
        !module_status_message[`CFS_B_WD];
    endproperty
    property p_pri_hold;
        $fell(module_status_message[`CFS_B_PRI])
            |-> $past(module_status_message[`CFS_B_PRI], PRI_PAST);
    endproperty
    a_cmd_id:     assert property (p_cmd_id)     else $error("command id wrong");
    a_cmd_period: assert property (p_cmd_period) else $error("command spacing wrong");
    a_sum_set:    assert property (p_sum_set)    else $error("summary flag missing");
    a_sum_fall:   assert property (p_sum_fall)   else $error("summary fell early");
    a_spare:      assert property (p_spare)      else $error("spare status bit set");
    a_valid:      assert property (p_valid)      else $error("status report stopped");
    a_no_wd:      assert property (p_no_wd)      else $error("watchdog tripped");
    a_pri_hold:   assert property (p_pri_hold)   else $error("primary fault short");
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench: controller and supervisor joined, plus a bare supervisor.
// Assumes the design files and cfs_consts.svh are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_consts.svh"
module tb;
    import cfs_pkg::*;
    // ----------------------------------------------------------------
    // Signals and instances.
    // ----------------------------------------------------------------
    localparam int LB_BIT [4] = '{`CFS_B_OCP, `CFS_B_OVP_HW, `CFS_B_OVP_SW, `CFS_B_FWRST};
    logic        core_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        profile_mode = 1'h0;
    logic        external_charge_enable = 1'h1;
    logic        sleep_mode = 1'h0;
    logic        charging = 1'h0;
    logic [3:0]  lat = 4'h0;
    logic        over_temp = 1'h0;
    logic        primary_unit_fault = 1'h0;
    logic        out_above_demand = 1'h0;
    cfs_volt_t   battery_volt = 16'h0064;
    logic        calibration_bad = 1'h0;
    cfs_prof_t   prof = 4'h0;
    logic        user_power_on = 1'h1;
    logic        user_clear = 1'h0;
    cfs_volt_t   user_setpoint = 16'h00c8;
    logic        power_enable;
    logic        fault_lamp;
    logic [31:0] can_bit_cycles;
    logic [31:0] ctl_bit_cycles;
    cfs_status_t seen_status;
    cfs_prof_t   seen_profile;
    logic        seen_fault;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    cfs_link_if link();
    cfs_link_if link2();
    always #25 core_clk = ~core_clk;
    cfs_controller #(.CMD_MS(5), .MS_CYC(4)) u_cfs_controller
    (
        .core_clk, .rst_n, .link(link.controller), .user_power_on, .user_clear,
        .user_setpoint, .seen_status, .seen_profile, .seen_fault,
        .can_bit_cycles(ctl_bit_cycles)
    );
    cfs_supervisor #(.WD_MS(20), .PRI_MS(10), .PSTAGE_MS(10), .CALM_MS(50), .MS_CYC(4))
        u_cfs_supervisor
    (
        .core_clk, .rst_n, .link(link.secondary_unit), .profile_mode, .external_charge_enable,
        .sleep_mode, .charging, .over_current(lat[0]), .over_temp, .over_volt_hard(lat[1]),
        .over_volt_soft(lat[2]), .firmware_reset(lat[3]), .primary_unit_fault, .out_above_demand,
        .battery_volt, .calibration_bad, .bad_profile_fault(prof[0]), .battery_temp_fault(prof[1]),
        .profile_battery_issue(prof[2]), .battery_volt_fault(prof[3]), .power_enable, .fault_lamp,
        .can_bit_cycles
    );
    cfs_supervisor #(.WD_MS(20), .PRI_MS(10), .PSTAGE_MS(10), .CALM_MS(50), .MS_CYC(4))
        u_cfs_supervisor_2
    (
        .core_clk, .rst_n, .link(link2.secondary_unit), .profile_mode, .external_charge_enable,
        .sleep_mode, .charging, .over_current(lat[0]), .over_temp, .over_volt_hard(lat[1]),
        .over_volt_soft(lat[2]), .firmware_reset(lat[3]), .primary_unit_fault, .out_above_demand,
        .battery_volt, .calibration_bad, .bad_profile_fault(prof[0]), .battery_temp_fault(prof[1]),
        .profile_battery_issue(prof[2]), .battery_volt_fault(prof[3]), .power_enable(),
        .fault_lamp(), .can_bit_cycles()
    );
    cfs_link_checker #(.CMD_CYC(20), .PRI_CYC(40)) u_cfs_link_checker
    (
        .core_clk, .rst_n, .cmd_valid(link.cmd_valid), .cmd_id(link.cmd_id),
        .clear_faults_request(link.clear_faults_request),
        .power_stage_request(link.power_stage_request), .volt_setpoint(link.volt_setpoint),
        .module_status_message(link.module_status_message),
        .profile_fault_message(link.profile_fault_message), .status_valid(link.status_valid)
    );
    // ----------------------------------------------------------------
    // Tasks.
    // ----------------------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task results();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task do_reset();
        rst_n <= 1'h0;
        tick(6);
        rst_n <= 1'h1;
    endtask
    task req(input logic clr, input logic pwr);
        user_clear <= clr;
        user_power_on <= pwr;
        tick(30);
        user_clear <= 1'h0;
    endtask
    task send2(input logic [10:0] id, input logic clr, input logic pwr);
        link2.cmd_id <= id;
        link2.clear_faults_request <= clr;
        link2.power_stage_request <= pwr;
        link2.cmd_valid <= 1'h1;
        tick(1);
        link2.cmd_valid <= 1'h0;
    endtask
    task lamp_check();
        int   t;
        logic last;
        t = 0;
        last = fault_lamp;
        repeat (1100)
        begin
            @(posedge core_clk);
            if (fault_lamp !== last)
                t++;
            last = fault_lamp;
        end
        chk(t != 0, 32'h1);
    endtask
    function automatic cfs_status_t fb(input int b);
        return (32'h1 << b) | (32'h1 << `CFS_B_SUMMARY);
    endfunction
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            results();
        end
    end
    // ----------------------------------------------------------------
    // Test sequence.
    // ----------------------------------------------------------------
    initial
    begin
        link2.cmd_valid <= 1'h0;
        link2.cmd_id <= `CFS_CMD_ID;
        link2.clear_faults_request <= 1'h0;
        link2.power_stage_request <= 1'h0;
        link2.volt_setpoint <= 16'h00c8;
        tick(1);
        do_reset();
        tick(60);
        chk(link2.module_status_message[`CFS_B_WD], 32'h0);
        chk(seen_status, 32'h0);
        chk(power_enable, 32'h1);
        chk(can_bit_cycles, `CFS_BIT_CYC);
        chk(ctl_bit_cycles, `CFS_BIT_CYC);
        tick(40);
        chk(link2.module_status_message[`CFS_B_WD], 32'h1);
        send2(11'h191, 1'h1, 1'h1);
        tick(5);
        chk(link2.module_status_message[`CFS_B_WD], 32'h1);
        send2(`CFS_CMD_ID, 1'h0, 1'h1);
        tick(5);
        chk(link2.module_status_message[`CFS_B_WD], 32'h1);
        tick(85);
        send2(`CFS_CMD_ID, 1'h1, 1'h1);
        tick(5);
        chk(link2.module_status_message[`CFS_B_WD], 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            lat[i] <= 1'h1;
            tick(4);
            lat[i] <= 1'h0;
            tick(10);
            chk(seen_status, fb(LB_BIT[i]));
            chk(power_enable, 32'h0);
            req(1'h1, 1'h1);
            chk(seen_status, fb(LB_BIT[i]));
            req(1'h0, 1'h0);
            req(1'h0, 1'h1);
            chk(seen_status, 32'h0);
            chk(power_enable, 32'h1);
        end
        over_temp <= 1'h1;
        tick(10);
        chk(seen_status, fb(`CFS_B_OTP));
        chk(seen_fault, 32'h1);
        lamp_check();
        over_temp <= 1'h0;
        tick(10);
        chk(seen_status, 32'h0);
        chk(fault_lamp, 32'h0);
        calibration_bad <= 1'h1;
        tick(4);
        calibration_bad <= 1'h0;
        tick(10);
        chk(seen_status, fb(`CFS_B_CAL));
        req(1'h0, 1'h0);
        req(1'h0, 1'h1);
        chk(seen_status, fb(`CFS_B_CAL));
        req(1'h1, 1'h1);
        chk(seen_status, 32'h0);
        battery_volt <= 16'h012c;
        charging <= 1'h1;
        out_above_demand <= 1'h1;
        tick(20);
        chk(seen_status, 32'h0);
        chk(power_enable, 32'h0);
        tick(40);
        chk(seen_status, fb(`CFS_B_PSTAGE));
        out_above_demand <= 1'h0;
        tick(10);
        chk(seen_status, fb(`CFS_B_PSTAGE));
        battery_volt <= 16'h0064;
        charging <= 1'h0;
        tick(10);
        chk(seen_status, 32'h0);
        primary_unit_fault <= 1'h1;
        tick(10);
        chk(seen_status, fb(`CFS_B_PRI));
        primary_unit_fault <= 1'h0;
        tick(25);
        chk(seen_status, fb(`CFS_B_PRI));
        tick(30);
        chk(seen_status, 32'h0);
        user_setpoint <= 16'h0032;
        tick(30);
        chk(power_enable, 32'h0);
        user_setpoint <= 16'h00c8;
        tick(30);
        chk(power_enable, 32'h1);
        prof <= 4'hf;
        tick(10);
        chk(seen_profile, 32'h0);
        prof <= 4'h0;
        profile_mode <= 1'h1;
        do_reset();
        tick(30);
        chk(power_enable, 32'h1);
        prof <= 4'h5;
        tick(10);
        chk(seen_profile, 32'h5);
        chk(seen_fault, 32'h1);
        chk(power_enable, 32'h0);
        prof <= 4'h0;
        tick(220);
        chk(seen_status, 32'h0);
        sleep_mode <= 1'h1;
        tick(10);
        chk(power_enable, 32'h0);
        sleep_mode <= 1'h0;
        external_charge_enable <= 1'h0;
        tick(10);
        chk(power_enable, 32'h0);
        external_charge_enable <= 1'h1;
        for (int k = 0; k < 11; k++)
        begin
            lat[0] <= 1'h1;
            tick(4);
            lat[0] <= 1'h0;
            tick(12);
            if (k == 4)
                tick(300);
            chk(seen_status, (k == 10) ? fb(`CFS_B_OCP) : 32'h0);
        end
        req(1'h1, 1'h1);
        chk(seen_status, fb(`CFS_B_OCP));
        chk(power_enable, 32'h0);
        prof <= 4'ha;
        tick(10);
        chk(link.profile_fault_message, 32'ha);
        chk(seen_profile, 32'ha);
        chk(link2.module_status_message[`CFS_B_WD], 32'h0);
        results();
    end
endmodule
`default_nettype wire
